/* shared/status_params.svh */
// Bit positions, reset values, codes and poll pattern of the status block
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH
// Standard event status bit positions
`define SES_PON_BIT      3'd7
`define SES_CMD_ERR_BIT  3'd5
`define SES_EXE_ERR_BIT  3'd4
`define SES_QRY_ERR_BIT  3'd2
`define SES_OPC_BIT      3'd0
`define SES_USED_MASK    8'hB5
// Status byte bit positions
`define STB_RQS_BIT      3'd6
`define STB_ESB_BIT      3'd5
`define STB_MAV_BIT      3'd4
// Reset values
`define SES_RESET        8'h80
`define REG_ZERO         8'h00
// Query error codes
`define QERR_INTERRUPTED 8'h01
`define QERR_DEADLOCK    8'h02
`define QERR_UNTERM      8'h03
// Parallel poll enable command byte pattern, bits 6 to 4
`define PPE_PATTERN      3'b110
`endif

/* shared/status_pkg.sv */
// Types shared by the status reporting block
`default_nettype none
package status_pkg;
    // Common command and query selectors from the parser
    typedef enum logic [3:0] {
        CMD_NONE     = 4'h0,
        CMD_ESR_QRY  = 4'h1,
        CMD_ESE_SET  = 4'h2,
        CMD_ESE_QRY  = 4'h3,
        CMD_SRE_SET  = 4'h4,
        CMD_SRE_QRY  = 4'h5,
        CMD_STB_QRY  = 4'h6,
        CMD_PRE_SET  = 4'h7,
        CMD_PRE_QRY  = 4'h8,
        CMD_OPC      = 4'h9,
        CMD_EER_QRY  = 4'hA,
        CMD_QER_QRY  = 4'hB
    } common_cmd_t;

    // Response formatter state
    typedef enum logic [1:0] {
        FMT_IDLE    = 2'b00,
        FMT_WAITING = 2'b01,
        FMT_SENDING = 2'b10
    } fmt_state_t;

    // One common command from the parser
    typedef struct packed {
        logic        valid;
        common_cmd_t cmd;
        logic [7:0]  data;
    } cmd_req_t;

    // Parallel poll configuration
    typedef struct packed {
        logic       enabled;
        logic       sense;
        logic [2:0] line;
    } pp_cfg_t;
endpackage
`default_nettype wire

/* rtl/gpib_status_reporting.sv */
// Status reporting and message-exchange error logic of the bus port
`timescale 1ns/1ns
`default_nettype none
`include "status_params.svh"

// Behaviour
// (RULE1) Talk addressed, formatter idle, queue empty: query error, code 3, parser reset.
// (RULE2) Response pending and terminator or two END messages: code 1, drop response.
// (RULE3) Response pending and queue full: query error, code 2, drop response.
// (RULE4) ist is one when poll enable AND status byte is nonzero.
// (RULE5) Poll enable byte: bits 6-4 are 110, bit 3 sense, bits 2-0 line.
// (RULE6) Controller sends configure then enable byte to arm the poll response.
// (RULE7) Poll enable register is written and read by common commands; feeds ist.
// (RULE8) Event status query returns contents then clears; its enable is read/write.
// (RULE9) Status byte bit 5 set when any event bit meets its enable bit.
// (RULE10) Any enabled status byte bit sets bit 6 and requests service.
// (RULE11) Bit 6 reads as summary by query and as request flag by poll.
// (RULE12) Bit 4 set when response ready, cleared after terminator sent; others unused.
// (RULE13) Event bits: power-on 7, command 5, execution 4, query 2, complete 0.
// (RULE14) Syntax error sets command error bit and resets the parser.
// (RULE15) Failed execution sets execution error bit and stores error number.
// (RULE16) Power-on zeroes all registers but event status, which loads 128.
// (RULE17) After power-on the device is local with keyboard active.
// (RULE18) Memory error at power-up warns and restores reset-command defaults.
// (RULE19) Parallel poll drives the configured line to sense when ist is one.
module gpib_status_reporting
    import status_pkg::*;
(
    input  wire logic       CORE_CLK_IN,
    input  wire logic       SRST_IN,
    input  wire cmd_req_t   CMD_IN,
    input  wire logic       TALK_ADDR_IN,
    input  wire logic       QUEUE_EMPTY_IN,
    input  wire logic       QUEUE_FULL_IN,
    input  wire logic       TERM_READ_IN,
    input  wire logic       MULTI_END_IN,
    input  wire logic       RESP_READY_IN,
    input  wire logic       RESP_TERM_SENT_IN,
    input  wire logic       SYNTAX_ERR_IN,
    input  wire logic       EXEC_ERR_IN,
    input  wire logic [7:0] EXEC_ERR_NUM_IN,
    input  wire logic       PPC_IN,
    input  wire logic       PPU_IN,
    input  wire logic       PP_CMD_VALID_IN,
    input  wire logic [7:0] PP_CMD_IN,
    input  wire logic       PP_ACTIVE_IN,
    input  wire logic       SERIAL_POLL_IN,
    input  wire logic       NVM_ERR_IN,
    input  wire logic       REMOTE_REQ_IN,
    input  wire logic       GO_LOCAL_IN,
    output logic [7:0]      RESP_DATA_OUT,
    output logic            RESP_VALID_OUT,
    output logic            PARSER_RESET_OUT,
    output logic            RESP_CLEAR_OUT,
    output logic            SRQ_OUT,
    output logic            IST_OUT,
    output logic [7:0]      DIO_OUT,
    output logic [7:0]      DIO_OE_N_OUT,
    output logic            LOCAL_OUT,
    output logic            NVM_WARN_OUT,
    output logic            DEFAULTS_LOAD_OUT
);

    // --------------------------------------------------------------
    // Registers and decode
    // --------------------------------------------------------------
    logic [7:0] event_status;
    logic [7:0] event_status_enable;
    logic [7:0] service_request_enable;
    logic [7:0] pp_enable;
    logic [7:0] exec_err;
    logic [7:0] query_err;
    logic       message_ready_bit;
    logic       boot_done;
    pp_cfg_t    pp_cfg;
    fmt_state_t fmt_state;
    logic [7:0] status_byte;
    logic       event_summary_bit;
    logic       rqs;
    logic       err_unterm;
    logic       err_interrupt;
    logic       err_deadlock;
    logic       qry_err;
    logic [7:0] next_qerr;
    logic       esr_read;
    logic       ist;

    // Returns true when the command selector matches and is valid
    function automatic logic is_cmd(input cmd_req_t r, input common_cmd_t c);
        is_cmd = r.valid && (r.cmd == c);
    endfunction

    // Returns true for a valid command that must be answered
    function automatic logic is_query(input cmd_req_t r);
        case (r.cmd)
            CMD_ESR_QRY, CMD_ESE_QRY, CMD_SRE_QRY, CMD_STB_QRY,
            CMD_PRE_QRY, CMD_EER_QRY, CMD_QER_QRY: is_query = r.valid;
            default: is_query = 1'b0;
        endcase
    endfunction

    // One-hot mask of the configured poll response line
    function automatic logic [7:0] line_mask(input logic [2:0] pos);
        line_mask = 8'h01 << pos;
    endfunction

    // Message-exchange error detection
    assign err_unterm    = TALK_ADDR_IN && (fmt_state == FMT_IDLE)
                           && QUEUE_EMPTY_IN;  // see (RULE1)
    assign err_interrupt = (fmt_state != FMT_IDLE)
                           && (TERM_READ_IN || MULTI_END_IN); // see (RULE2)
    assign err_deadlock  = (fmt_state != FMT_IDLE) && QUEUE_FULL_IN
                           && !err_interrupt;  // see (RULE3)
    assign qry_err       = err_unterm || err_interrupt || err_deadlock;
    assign next_qerr     = err_interrupt ? `QERR_INTERRUPTED :
                           err_deadlock  ? `QERR_DEADLOCK : `QERR_UNTERM;
    assign esr_read      = is_cmd(CMD_IN, CMD_ESR_QRY);

    // Summary bits of the status byte
    assign event_summary_bit = |(event_status & event_status_enable); // see (RULE9)
    assign status_byte = {1'b0, rqs, event_summary_bit, message_ready_bit,
                          4'h0};                         // see (RULE12)
    // Service request from enabled bits, bit 6 itself excluded; built from
    // the summary sources so that no loop runs through the status byte
    assign rqs = |({2'b00, event_summary_bit, message_ready_bit, 4'h0}
                   & service_request_enable);            // see (RULE10)
    assign ist = |(pp_enable & status_byte);             // see (RULE4)

    // --------------------------------------------------------------
    // Event status register
    // --------------------------------------------------------------
    // Events set bits after the read clear, so a same-cycle event wins
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            event_status <= `SES_RESET;                  // see (RULE16)
        end else begin
            event_status <= (esr_read ? `REG_ZERO : event_status) // see (RULE8)
                | ({7'h00, qry_err} << `SES_QRY_ERR_BIT)       // see (RULE13)
                | ({7'h00, SYNTAX_ERR_IN} << `SES_CMD_ERR_BIT) // see (RULE14)
                | ({7'h00, EXEC_ERR_IN} << `SES_EXE_ERR_BIT)   // see (RULE15)
                | ({7'h00, is_cmd(CMD_IN, CMD_OPC)} << `SES_OPC_BIT);
        end
    end

    // --------------------------------------------------------------
    // Enable and error registers
    // --------------------------------------------------------------
    // Writable enables, cleared at power-on and on a memory error at power-up (first cycle after reset)
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN || (!boot_done && NVM_ERR_IN)) begin
            event_status_enable    <= `REG_ZERO;         // see (RULE16)
            service_request_enable <= `REG_ZERO;
            pp_enable              <= `REG_ZERO;         // see (RULE18)
        end else begin
            if (is_cmd(CMD_IN, CMD_ESE_SET))
                event_status_enable <= CMD_IN.data;      // see (RULE8)
            if (is_cmd(CMD_IN, CMD_SRE_SET))
                service_request_enable <= CMD_IN.data;
            if (is_cmd(CMD_IN, CMD_PRE_SET))
                pp_enable <= CMD_IN.data;                // see (RULE7)
        end
    end

    // Error number registers
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            exec_err  <= `REG_ZERO;
            query_err <= `REG_ZERO;
        end else begin
            if (EXEC_ERR_IN)
                exec_err <= EXEC_ERR_NUM_IN;             // see (RULE15)
            if (qry_err)
                query_err <= next_qerr;                  // see (RULE1)
        end
    end

    // --------------------------------------------------------------
    // Response formatter tracking
    // --------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            fmt_state         <= FMT_IDLE;
            message_ready_bit <= 1'b0;
        end else begin
            case (fmt_state)
                FMT_IDLE: begin
                    if (RESP_READY_IN) begin
                        fmt_state         <= FMT_WAITING;
                        message_ready_bit <= 1'b1;       // see (RULE12)
                    end
                end
                FMT_WAITING, FMT_SENDING: begin
                    if (err_interrupt || err_deadlock) begin
                        fmt_state         <= FMT_IDLE;   // see (RULE2)
                        message_ready_bit <= 1'b0;       // see (RULE3)
                    end else if (RESP_TERM_SENT_IN) begin
                        fmt_state         <= FMT_IDLE;
                        message_ready_bit <= 1'b0;       // see (RULE12)
                    end else if (TALK_ADDR_IN) begin
                        fmt_state <= FMT_SENDING;
                    end
                end
                default: begin
                    fmt_state         <= FMT_IDLE;
                    message_ready_bit <= 1'b0;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Parallel poll configuration and response
    // --------------------------------------------------------------
    // Configure arms, then an enable byte of the right form is taken
    logic pp_armed;
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            pp_armed <= 1'b0;
            pp_cfg   <= '0;
        end else begin
            if (PPU_IN) begin
                pp_cfg.enabled <= 1'b0;
                pp_armed       <= 1'b0;
            end else if (PPC_IN) begin
                pp_armed <= 1'b1;                        // see (RULE6)
            end else if (pp_armed && PP_CMD_VALID_IN) begin
                pp_armed <= 1'b0;
                if (PP_CMD_IN[6:4] == `PPE_PATTERN) begin // see (RULE5)
                    pp_cfg.enabled <= 1'b1;
                    pp_cfg.sense   <= PP_CMD_IN[3];
                    pp_cfg.line    <= PP_CMD_IN[2:0];
                end
            end
        end
    end

    // Registered summary outputs
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            IST_OUT <= 1'b0;
            SRQ_OUT <= 1'b0;
        end else begin
            IST_OUT <= ist;                              // see (RULE4)
            SRQ_OUT <= rqs;                              // see (RULE10)
        end
    end

    // Poll line drive: the selected line is driven only while ist is one
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            DIO_OUT      <= `REG_ZERO;
            DIO_OE_N_OUT <= 8'hFF;
        end else begin
            DIO_OUT      <= pp_cfg.sense ? line_mask(pp_cfg.line)
                                         : `REG_ZERO;
            DIO_OE_N_OUT <= (PP_ACTIVE_IN && pp_cfg.enabled && ist)
                            ? ~line_mask(pp_cfg.line) : 8'hFF; // see (RULE19)
        end
    end

    // Query answers, one cycle after the command
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            RESP_DATA_OUT  <= `REG_ZERO;
            RESP_VALID_OUT <= 1'b0;
        end else begin
            RESP_VALID_OUT <= is_query(CMD_IN);          // see (RULE8)
            case (CMD_IN.cmd)
                CMD_ESR_QRY: RESP_DATA_OUT <= event_status;   // see (RULE8)
                CMD_ESE_QRY: RESP_DATA_OUT <= event_status_enable;
                CMD_SRE_QRY: RESP_DATA_OUT <= service_request_enable;
                CMD_PRE_QRY: RESP_DATA_OUT <= pp_enable;      // see (RULE7)
                CMD_EER_QRY: RESP_DATA_OUT <= exec_err;
                CMD_QER_QRY: RESP_DATA_OUT <= query_err;
                CMD_STB_QRY: RESP_DATA_OUT <= status_byte;    // see (RULE11)
                default:     RESP_DATA_OUT <= status_byte;
            endcase
            // Serial poll returns the latched request flag in bit 6
            if (SERIAL_POLL_IN)
                RESP_DATA_OUT <= {1'b0, SRQ_OUT, status_byte[5:0]};
        end
    end

    // --------------------------------------------------------------
    // Control outputs, local state and power-up check
    // --------------------------------------------------------------
    assign PARSER_RESET_OUT = err_unterm || SYNTAX_ERR_IN;  // see (RULE14)
    assign RESP_CLEAR_OUT   = err_interrupt || err_deadlock; // see (RULE2)

    // Power-up memory check happens on the first cycle after reset
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            boot_done         <= 1'b0;
            NVM_WARN_OUT      <= 1'b0;
            DEFAULTS_LOAD_OUT <= 1'b0;
            LOCAL_OUT         <= 1'b1;                   // see (RULE17)
        end else begin
            boot_done         <= 1'b1;
            DEFAULTS_LOAD_OUT <= !boot_done && NVM_ERR_IN; // see (RULE18)
            if (!boot_done && NVM_ERR_IN)
                NVM_WARN_OUT <= 1'b1;
            if (REMOTE_REQ_IN)
                LOCAL_OUT <= 1'b0;
            else if (GO_LOCAL_IN)
                LOCAL_OUT <= 1'b1;
        end
    end

endmodule // gpib_status_reporting
`default_nettype wire

/* tb/gpib_status_reporting_properties.sv */
// Port-level assertions of the status reporting block
`timescale 1ns/1ns
`default_nettype none
module gpib_status_reporting_properties
    import status_pkg::*;
(
    input wire logic       CORE_CLK_IN,
    input wire logic       SRST_IN,
    input wire cmd_req_t   CMD_IN,
    input wire logic       TERM_READ_IN,
    input wire logic       MULTI_END_IN,
    input wire logic       QUEUE_FULL_IN,
    input wire logic       SYNTAX_ERR_IN,
    input wire logic       SERIAL_POLL_IN,
    input wire logic       PP_ACTIVE_IN,
    input wire logic [7:0] RESP_DATA_OUT,
    input wire logic       RESP_VALID_OUT,
    input wire logic       PARSER_RESET_OUT,
    input wire logic       RESP_CLEAR_OUT,
    input wire logic       SRQ_OUT,
    input wire logic [7:0] DIO_OE_N_OUT
);
    // --------------------------------
    // Assertions
    // --------------------------------
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (SRST_IN);
    // A query that must be answered
    logic qry;
    assign qry = CMD_IN.valid && CMD_IN.cmd inside {CMD_ESR_QRY, CMD_ESE_QRY,
        CMD_SRE_QRY, CMD_STB_QRY, CMD_PRE_QRY, CMD_EER_QRY, CMD_QER_QRY};
    a_parser_reset:
        assert property (SYNTAX_ERR_IN |-> PARSER_RESET_OUT) else $error("no reset");
    a_clear_cause:
        assert property (RESP_CLEAR_OUT |-> TERM_READ_IN || MULTI_END_IN ||
            QUEUE_FULL_IN) else $error("stray clear");
    a_query_answered:
        assert property (qry |=> RESP_VALID_OUT) else $error("no answer");
    a_answer_cause:
        assert property (RESP_VALID_OUT |-> $past(qry || SERIAL_POLL_IN))
        else $error("stray answer");
    a_status_unused:
        assert property ($past(CMD_IN.valid && CMD_IN.cmd == CMD_STB_QRY) |->
            !RESP_DATA_OUT[7] && RESP_DATA_OUT[3:0] == 4'h0) else $error("bits");
    a_poll_rqs:
        assert property ($past(SERIAL_POLL_IN) |-> RESP_DATA_OUT[6] ==
            $past(SRQ_OUT)) else $error("poll bit 6");
    a_dio_released:
        assert property (!PP_ACTIVE_IN ##1 !PP_ACTIVE_IN |->
            DIO_OE_N_OUT == 8'hFF) else $error("line driven");
    a_reset_state:
        assert property ($fell(SRST_IN) |-> !SRQ_OUT && !RESP_VALID_OUT &&
            DIO_OE_N_OUT == 8'hFF) else $error("reset state");
    // Main scenarios
    c_esr_query: cover property (CMD_IN.valid && CMD_IN.cmd == CMD_ESR_QRY);
    c_serial_poll: cover property (SERIAL_POLL_IN && SRQ_OUT);
    c_poll_drive: cover property (PP_ACTIVE_IN && DIO_OE_N_OUT != 8'hFF);
endmodule // gpib_status_reporting_properties
`default_nettype wire

/* tb/poll_controller_model.sv */
// Bus controller model that configures the parallel poll response
`timescale 1ns/1ns
`default_nettype none
module poll_controller_model (
    input  wire logic       clk_in,
    input  wire logic       start_in,
    input  wire logic [7:0] byte_in,
    output logic            ppc_out,
    output logic            ppu_out,
    output logic            pp_cmd_valid_out,
    output logic [7:0]      pp_cmd_out
);
    // --------------------------------
    // Configure sequence
    // --------------------------------
    initial {ppc_out, pp_cmd_valid_out, pp_cmd_out} = 10'h0AA;
    assign ppu_out = 1'b0;
    // Configure first, enable byte next cycle, data lines toggle when idle
    always @(posedge clk_in) begin
        ppc_out          <= start_in;
        pp_cmd_valid_out <= ppc_out;
        pp_cmd_out       <= ppc_out ? byte_in : ~pp_cmd_out;
    end
endmodule // poll_controller_model
`default_nettype wire

/* tb/gpib_status_reporting_tb.sv */
// Self-checking bench of the status reporting block
`timescale 1ns/1ns
`default_nettype none
module gpib_status_reporting_tb
    import status_pkg::*;
;
    // --------------------------------
    // Bench signals and tasks
    // --------------------------------
    logic        clk, srst, cfg, ppc, ppu, ppv;
    logic        rvalid, prst, rclr, srq, ist, local_st, warn, defl;
    logic [13:0] pin;
    logic [7:0]  num, cfg_byte, ppb, rdata, dio, oe_n;
    cmd_req_t    cmd;
    int          bad_count, checks_done, k;
    // Ordinary cases: command, data, answer expected, answer value
    logic [20:0] rows [13] = '{
        {CMD_ESR_QRY, 8'h00, 1'b1, 8'h80},
        {CMD_ESR_QRY, 8'h00, 1'b1, 8'h00},
        {CMD_ESE_SET, 8'h24, 1'b0, 8'h00},
        {CMD_ESE_QRY, 8'h00, 1'b1, 8'h24},
        {CMD_SRE_SET, 8'h20, 1'b0, 8'h00},
        {CMD_SRE_QRY, 8'h00, 1'b1, 8'h20},
        {CMD_PRE_SET, 8'h40, 1'b0, 8'h00},
        {CMD_PRE_QRY, 8'h00, 1'b1, 8'h40},
        {CMD_EER_QRY, 8'h00, 1'b1, 8'h00},
        {CMD_QER_QRY, 8'h00, 1'b1, 8'h00},
        {CMD_STB_QRY, 8'h00, 1'b1, 8'h00},
        {CMD_OPC,     8'h00, 1'b0, 8'h00},
        {CMD_ESR_QRY, 8'h00, 1'b1, 8'h01}
    };
    task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic send(logic [20:0] r);
        cmd = {1'b1, r[20:9]};
        tick;
        chk("valid", {7'h0, rvalid}, {7'h0, r[8]});
        if (r[8]) chk("answer", rdata, r[7:0]);
        cmd = '0;
        tick;
    endtask
    task automatic pulse(int i, logic [1:0] e);
        pin[i] = 1'b1;
        #1 chk("rst_clr", {6'h0, prst, rclr}, {6'h0, e});
        tick;
        pin[i] = 1'b0;
    endtask
    task automatic arm_poll(logic [7:0] b);
        pin[9] = 1'b0;
        cfg_byte = b;
        cfg = 1'b1;
        tick;
        cfg = 1'b0;
        repeat (3) tick;
        pin[9] = 1'b1;
        repeat (2) tick;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    gpib_status_reporting gpib_status_reporting_inst (
        .CORE_CLK_IN(clk), .SRST_IN(srst), .CMD_IN(cmd),
        .TALK_ADDR_IN(pin[0]), .QUEUE_EMPTY_IN(pin[1]),
        .QUEUE_FULL_IN(pin[2]), .TERM_READ_IN(pin[3]), .MULTI_END_IN(pin[4]),
        .RESP_READY_IN(pin[5]), .RESP_TERM_SENT_IN(pin[6]),
        .SYNTAX_ERR_IN(pin[7]), .EXEC_ERR_IN(pin[8]), .EXEC_ERR_NUM_IN(num),
        .PPC_IN(ppc), .PPU_IN(ppu), .PP_CMD_VALID_IN(ppv), .PP_CMD_IN(ppb),
        .PP_ACTIVE_IN(pin[9]), .SERIAL_POLL_IN(pin[10]), .NVM_ERR_IN(pin[11]),
        .REMOTE_REQ_IN(pin[12]), .GO_LOCAL_IN(pin[13]), .RESP_DATA_OUT(rdata),
        .RESP_VALID_OUT(rvalid), .PARSER_RESET_OUT(prst),
        .RESP_CLEAR_OUT(rclr), .SRQ_OUT(srq), .IST_OUT(ist), .DIO_OUT(dio),
        .DIO_OE_N_OUT(oe_n), .LOCAL_OUT(local_st), .NVM_WARN_OUT(warn),
        .DEFAULTS_LOAD_OUT(defl));
    poll_controller_model poll_controller_model_inst (
        .clk_in(clk), .start_in(cfg), .byte_in(cfg_byte), .ppc_out(ppc),
        .ppu_out(ppu), .pp_cmd_valid_out(ppv), .pp_cmd_out(ppb));
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #200000;
        bad_count++;
        finish_test;
    end
    // Main sequence
    initial begin
        {srst, cfg, cmd, pin, num, cfg_byte} = {2'b10, 13'h0, 14'h2, 16'h2A00};
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        chk("local", {7'h0, local_st}, 8'h01);
        foreach (rows[i]) send(rows[i]);
        pulse(7, 2'b10);
        for (k = 0; k < 8 && srq !== 1'b1; k++) tick;
        chk("srq", {7'h0, srq}, 8'h01);
        send({CMD_STB_QRY, 8'h00, 1'b1, 8'h60});
        pulse(10, 2'b00);
        chk("poll", rdata, 8'h60);
        chk("ist", {7'h0, ist}, 8'h01);
        arm_poll(8'h29);
        chk("bad_ppe", oe_n, 8'hFF);
        arm_poll(8'hE9);
        chk("pp", {6'h0, $onehot(~oe_n), |(dio & ~oe_n)}, 8'h03);
        send({CMD_ESR_QRY, 8'h00, 1'b1, 8'h20});
        for (k = 0; k < 8 && ist !== 1'b0; k++) tick;
        tick;
        chk("pp_idle", {7'h0, |(dio & ~oe_n)}, 8'h00);
        pin[9] = 1'b0;
        pulse(0, 2'b10);
        send({CMD_QER_QRY, 8'h00, 1'b1, 8'h03});
        send({CMD_ESR_QRY, 8'h00, 1'b1, 8'h04});
        pulse(5, 2'b00);
        send({CMD_STB_QRY, 8'h00, 1'b1, 8'h10});
        pulse(3, 2'b01);
        send({CMD_QER_QRY, 8'h00, 1'b1, 8'h01});
        pulse(5, 2'b00);
        pulse(2, 2'b01);
        send({CMD_QER_QRY, 8'h00, 1'b1, 8'h02});
        send({CMD_ESR_QRY, 8'h00, 1'b1, 8'h04});
        pulse(5, 2'b00);
        pulse(4, 2'b01);
        send({CMD_QER_QRY, 8'h00, 1'b1, 8'h01});
        send({CMD_ESR_QRY, 8'h00, 1'b1, 8'h04});
        pulse(5, 2'b00);
        pulse(6, 2'b00);
        send({CMD_STB_QRY, 8'h00, 1'b1, 8'h00});
        pulse(8, 2'b00);
        send({CMD_EER_QRY, 8'h00, 1'b1, 8'h2A});
        send({CMD_ESR_QRY, 8'h00, 1'b1, 8'h10});
        pulse(12, 2'b00);
        chk("remote", {7'h0, local_st}, 8'h00);
        pulse(13, 2'b00);
        chk("local2", {7'h0, local_st}, 8'h01);
        {pin[11], srst} = 2'b11;
        repeat (16) tick;
        srst = 1'b0;
        for (k = 0; k < 8 && defl !== 1'b1; k++) tick;
        chk("defaults", {6'h0, defl, warn}, 8'h03);
        send({CMD_SRE_QRY, 8'h00, 1'b1, 8'h00});
        send({CMD_ESR_QRY, 8'h00, 1'b1, 8'h80});
        finish_test;
    end
endmodule // gpib_status_reporting_tb
// Port checker beside the design instance
bind gpib_status_reporting gpib_status_reporting_properties
    gpib_status_reporting_properties_inst (
    .CORE_CLK_IN(CORE_CLK_IN), .SRST_IN(SRST_IN), .CMD_IN(CMD_IN),
    .TERM_READ_IN(TERM_READ_IN), .MULTI_END_IN(MULTI_END_IN),
    .QUEUE_FULL_IN(QUEUE_FULL_IN), .SYNTAX_ERR_IN(SYNTAX_ERR_IN),
    .SERIAL_POLL_IN(SERIAL_POLL_IN), .PP_ACTIVE_IN(PP_ACTIVE_IN),
    .RESP_DATA_OUT(RESP_DATA_OUT), .RESP_VALID_OUT(RESP_VALID_OUT),
    .PARSER_RESET_OUT(PARSER_RESET_OUT), .RESP_CLEAR_OUT(RESP_CLEAR_OUT),
    .SRQ_OUT(SRQ_OUT), .DIO_OE_N_OUT(DIO_OE_N_OUT));
`default_nettype wire
